/* rtl/lsd_control.sv */
// Top of the low-side driver control: register port, over-current handling and the switch outputs.
// Assumes a synchronous over-current detector input and a single 25 MHz system clock.
//
// Functional notes
// R1: Bit 0 of the configuration register biases the driver; one enables it.
// R2: With the data bit as source, zero turns the switch off, one on.
// R3: Data read gives stored bit when disabled, selected source level when enabled.
// R4: In run mode an enabled driver follows the selected data, timer or PWM source.
// R5: Entering stop mode clears the data bit.
// R6: Throughout stop mode the driver is held disabled and off.
// R7: Leaving stop re-enables the driver; timer or PWM sources resume by themselves.
// R8: After stop with data source, switch stays off until software writes one.
// R9: Software turns timer or PWM drive off before stop if it must stay off.
// R10: Software waits the settling time after enabling before switching on.
// R11: An over-current report sets the over-current flag.
// R12: While the flag is set the switch is forced off.
// R13: Clearing the flag returns control to the selected source.
// R14: Writing one clears the flag; writing zero leaves it.
// R15: Interrupt requested while flag and enable bit 7 at offset six are set.
// R16: The interrupt is raised only in run mode, never in stop mode.
// R17: Stop entry and exit leave the over-current flag unchanged.
// R18: Test register at offset three reads anytime, writes only in special mode.
// R19: Reset clears data, enable, interrupt enable and flag; output off, no request.
`timescale 1ns/1ps
`include "lsd_map.svh"
module lsd_control #(
    parameter int unsigned ADDR_W = `LSD_ADDR_W
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port.
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // Mode inputs.
    input wire logic stopReq,
    input wire logic specialMode,
    // Routed sources from the port routing module.
    input wire lsd_pkg::source_t sourceSelect,
    input wire logic timerLevel,
    input wire logic pwmLevel,
    // Analog stage.
    input wire logic overcurrentDetect,
    output logic switchOutputPin,
    output logic driverBiasEnable,
    // Interrupt.
    output logic driverIrqRequest
);
    lsd_ctrl_if ctrl ();

    logic dataBit;
    logic biasEnable;
    logic ocIrqEnable;
    logic ocFlag;
    logic [7:0] factoryTest;
    logic switchOn;
    logic biasOn;
    logic [7:0] next_rdata;
    logic wrData;
    logic wrConfig;
    logic wrTest;
    logic wrIe;
    logic wrIf;

    assign ctrl.dataBit = dataBit;
    assign ctrl.biasEnable = biasEnable;
    assign ctrl.ocFlag = ocFlag;

    lsd_drive_core u_core (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .stopReq(stopReq),
        .sourceSelect(sourceSelect),
        .timerLevel(timerLevel),
        .pwmLevel(pwmLevel),
        .ctrl(ctrl),
        .switchOn(switchOn),
        .biasOn(biasOn)
    );

    assign wrData = regWrite && (regAddr == `LSD_OFF_DRIVE_LEVEL);
    assign wrConfig = regWrite && (regAddr == `LSD_OFF_DRIVER_CONFIG);
    assign wrTest = regWrite && (regAddr == `LSD_OFF_FACTORY_TEST);
    assign wrIe = regWrite && (regAddr == `LSD_OFF_IRQ_ENABLE);
    assign wrIf = regWrite && (regAddr == `LSD_OFF_IRQ_FLAG);

    // Stop entry wins over a software write in the same cycle, so stop always starts with the bit low.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dataBit <= 1'b0;  // see R19
        end else if (ctrl.stopEntry || ctrl.stopActive) begin
            dataBit <= 1'b0;  // see R5, R8
        end else if (wrData) begin
            dataBit <= regWdata[`LSD_BIT_DRIVE_LEVEL];  // see R2
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            biasEnable <= 1'b0;  // see R19
        end else if (wrConfig) begin
            biasEnable <= regWdata[`LSD_BIT_BIAS_ENABLE];  // see R1
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ocIrqEnable <= 1'b0;  // see R19
        end else if (wrIe) begin
            ocIrqEnable <= regWdata[`LSD_BIT_OC_IRQ_ENABLE];
        end
    end

    // A detection in the clearing cycle keeps the flag set; stop mode does not touch it.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ocFlag <= 1'b0;  // see R19
        end else if (overcurrentDetect) begin
            ocFlag <= 1'b1;  // see R11, R17
        end else if (wrIf && regWdata[`LSD_BIT_OC_FLAG]) begin
            ocFlag <= 1'b0;  // see R14
        end
    end

    // The test byte only steers nothing here; it is kept so factory code can read back what it wrote.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            factoryTest <= `LSD_RST_FACTORY_TEST;
        end else if (wrTest && specialMode) begin
            factoryTest <= regWdata;  // see R18
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        unique case (regAddr)
            `LSD_OFF_DRIVE_LEVEL: begin
                next_rdata[`LSD_BIT_DRIVE_LEVEL] = biasEnable ? ctrl.selectedLevel : dataBit;  // see R3
            end
            `LSD_OFF_DRIVER_CONFIG: begin
                next_rdata[`LSD_BIT_BIAS_ENABLE] = biasEnable;
            end
            `LSD_OFF_FACTORY_TEST: begin
                next_rdata = factoryTest;  // see R18
            end
            `LSD_OFF_IRQ_ENABLE: begin
                next_rdata[`LSD_BIT_OC_IRQ_ENABLE] = ocIrqEnable;
            end
            `LSD_OFF_IRQ_FLAG: begin
                next_rdata[`LSD_BIT_OC_FLAG] = ocFlag;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end else begin
            regRdata <= 8'h00;
        end
    end

    // Outputs are registered, so the switch reacts one cycle after its cause.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            switchOutputPin <= 1'b0;  // see R19
            driverBiasEnable <= 1'b0;
        end else begin
            switchOutputPin <= switchOn;  // see R4, R6, R12
            driverBiasEnable <= biasOn;  // see R1, R7
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            driverIrqRequest <= 1'b0;
        end else begin
            driverIrqRequest <= ocFlag && ocIrqEnable && !ctrl.stopActive && !stopReq;  // see R15, R16
        end
    end
endmodule

/* rtl/lsd_map.svh */
// Register offsets, field positions, reset values and source select codes of the low-side driver control.
// Included by the design modules; definitions only.
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH
`define LSD_ADDR_W 3
`define LSD_OFF_DRIVE_LEVEL 3'h0
`define LSD_OFF_DRIVER_CONFIG 3'h1
`define LSD_OFF_RESERVED_TWO 3'h2
`define LSD_OFF_FACTORY_TEST 3'h3
`define LSD_OFF_RESERVED_FOUR 3'h4
`define LSD_OFF_RESERVED_FIVE 3'h5
`define LSD_OFF_IRQ_ENABLE 3'h6
`define LSD_OFF_IRQ_FLAG 3'h7
`define LSD_BIT_DRIVE_LEVEL 0
`define LSD_BIT_BIAS_ENABLE 0
`define LSD_BIT_OC_IRQ_ENABLE 7
`define LSD_BIT_OC_FLAG 0
`define LSD_RST_FACTORY_TEST 8'h00
`define LSD_SEL_DATA 2'h0
`define LSD_SEL_TIMER 2'h1
`define LSD_SEL_PWM 2'h2
`endif

/* rtl/lsd_pkg.sv */
// Types shared by the low-side driver control modules.
// Assumes lsd_map.svh is on the include path.
package lsd_pkg;
    typedef enum logic [1:0] {
        SRC_DATA = 2'h0,
        SRC_TIMER = 2'h1,
        SRC_PWM = 2'h2
    } source_t;
    typedef enum logic [1:0] {
        PM_RUN = 2'b01,
        PM_STOP = 2'b10
    } power_t;
endpackage

/* rtl/lsd_ctrl_if.sv */
// Interface between the register file and the driver core of the low-side driver control.
// Both ends run on the single system clock.
`timescale 1ns/1ps
interface lsd_ctrl_if;
    logic dataBit;
    logic biasEnable;
    logic ocFlag;
    logic stopActive;
    logic stopEntry;
    logic selectedLevel;
    modport regs (
        output dataBit,
        output biasEnable,
        output ocFlag,
        input stopActive,
        input stopEntry,
        input selectedLevel
    );
    modport core (
        input dataBit,
        input biasEnable,
        input ocFlag,
        output stopActive,
        output stopEntry,
        output selectedLevel
    );
endinterface

/* rtl/lsd_drive_core.sv */
// Source selection and power mode tracking for the low-side switch.
// Assumes the routing choice and the stop request are synchronous to clk_sys.
`timescale 1ns/1ps
`include "lsd_map.svh"
module lsd_drive_core (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Mode and routed sources.
    input wire logic stopReq,
    input wire lsd_pkg::source_t sourceSelect,
    input wire logic timerLevel,
    input wire logic pwmLevel,
    // Register side.
    lsd_ctrl_if.core ctrl,
    // Outputs toward the pin stage.
    output logic switchOn,
    output logic biasOn
);
    lsd_pkg::power_t powerState;
    logic selLevel;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            powerState <= lsd_pkg::PM_RUN;
        end else begin
            unique case (powerState)
                lsd_pkg::PM_RUN: begin
                    if (stopReq) begin
                        powerState <= lsd_pkg::PM_STOP;
                    end
                end
                lsd_pkg::PM_STOP: begin
                    if (!stopReq) begin
                        powerState <= lsd_pkg::PM_RUN;
                    end
                end
                default: begin
                    powerState <= lsd_pkg::PM_RUN;
                end
            endcase
        end
    end

    always_comb begin
        unique case (sourceSelect)
            lsd_pkg::SRC_TIMER: selLevel = timerLevel;
            lsd_pkg::SRC_PWM: selLevel = pwmLevel;
            default: selLevel = ctrl.dataBit;
        endcase
    end

    assign ctrl.stopActive = (powerState == lsd_pkg::PM_STOP);
    assign ctrl.stopEntry = (powerState == lsd_pkg::PM_RUN) && stopReq;
    assign ctrl.selectedLevel = selLevel;

    // Stop forces both bias and drive off; leaving stop restores bias, and timer or PWM drive, with no software step.
    always_comb begin
        biasOn = ctrl.biasEnable && !ctrl.stopActive;  // see R1, R6, R7
        switchOn = biasOn && selLevel && !ctrl.ocFlag;  // see R4, R12, R13
    end
endmodule

/* dv/lsd_control_assertions.sv */
// Port-level assertions for lsd_control.
// Assumes one clock and outputs registered one cycle behind their cause.
`timescale 1ns/1ps
module lsd_control_assertions #(
    parameter int unsigned ADDR_W = 3
) (
    // Clock, reset and register port.
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    // Mode, sense and outputs.
    input wire logic stopReq,
    input wire logic overcurrentDetect,
    input wire logic switchOutputPin,
    input wire logic driverBiasEnable,
    input wire logic driverIrqRequest
);
    // Shadows are rebuilt from bus traffic and the over-current input, so no internal signal is needed.
    logic ieOn, cfgOn, flagOn;
    wire calm = !(flagOn && ieOn) && !regWrite && !overcurrentDetect;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {ieOn, cfgOn, flagOn} <= 3'b000;
        end else begin
            ieOn <= (regWrite && regAddr == 3'h6) ? regWdata[7] : ieOn;
            cfgOn <= (regWrite && regAddr == 3'h1) ? regWdata[0] : cfgOn;
            flagOn <= overcurrentDetect || (flagOn && !(regWrite && regAddr == 3'h7 && regWdata[0]));
        end
    end
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence runIdle;
        !stopReq [*3];
    endsequence
    sequence stopHeld;
        stopReq [*3];
    endsequence
    a_oc_cutoff: assert property (flagOn |=> !switchOutputPin)
        else $error("switch on with flag");
    a_irq_raise: assert property (runIdle ##0 (flagOn && ieOn && !regWrite) |=> driverIrqRequest)
        else $error("irq missing");
    a_irq_masked: assert property (calm [*2] |-> !driverIrqRequest)
        else $error("irq without cause");
    a_stop_idle: assert property (stopHeld |-> !switchOutputPin && !driverBiasEnable)
        else $error("driver live in stop");
    a_stop_irq: assert property (stopHeld |-> !driverIrqRequest)
        else $error("irq in stop");
    a_bias_on: assert property ((cfgOn && !stopReq) [*3] |-> driverBiasEnable)
        else $error("bias missing");
    a_bias_off: assert property (!cfgOn [*2] |-> !driverBiasEnable)
        else $error("bias unasked");
    a_cfg_read: assert property (regRead && regAddr == 3'h1 |=> regRdata == {7'h00, cfgOn})
        else $error("config readback");
endmodule
bind lsd_control lsd_control_assertions #(.ADDR_W(ADDR_W)) lsd_control_assertions_i (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopReq(stopReq),
    .overcurrentDetect(overcurrentDetect), .switchOutputPin(switchOutputPin),
    .driverBiasEnable(driverBiasEnable), .driverIrqRequest(driverIrqRequest)
);

/* dv/lsd_load_model.sv */
// Load on the switch output: healthy, or shorted on bench command.
// A short draws excess current only while the biased switch conducts.
`timescale 1ns/1ps
module lsd_load_model (
    // Driver side and bench control.
    input wire logic switchOn,
    input wire logic biasOn,
    input wire logic shortLoad,
    // Toward the over-current sense.
    output logic overcurrentDetect
);
    assign overcurrentDetect = shortLoad && switchOn && biasOn;
endmodule

/* dv/tb_low_side_driver_control.sv */
// Self-checking bench for lsd_control with a load model on its output.
// Assumes outputs settle within three cycles of their cause.
`timescale 1ns/1ps
module tb_low_side_driver_control;
    localparam int SETTLE = 4;
    logic clk_sys, rstn, regWrite, regRead, stopReq, specialMode;
    logic timerLevel, pwmLevel, shortLoad, overcurrentDetect;
    logic switchOutputPin, driverBiasEnable, driverIrqRequest;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata;
    lsd_pkg::source_t sourceSelect;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Rows: source, timer, pwm, data bit, expected level; unselected inputs oppose it.
    // The last row uses the spare source code, which must fall back to the data bit.
    logic [5:0] rows [7] = '{6'h0c, 6'h03, 6'h19, 6'h16, 6'h25, 6'h2a, 6'h33};
    lsd_control lsd_control_i (
        .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .stopReq(stopReq), .specialMode(specialMode),
        .sourceSelect(sourceSelect), .timerLevel(timerLevel), .pwmLevel(pwmLevel),
        .overcurrentDetect(overcurrentDetect), .switchOutputPin(switchOutputPin),
        .driverBiasEnable(driverBiasEnable), .driverIrqRequest(driverIrqRequest)
    );
    lsd_load_model lsd_load_model_i (
        .switchOn(switchOutputPin), .biasOn(driverBiasEnable), .shortLoad(shortLoad),
        .overcurrentDetect(overcurrentDetect)
    );
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask
    // Switch, bias and interrupt compared together after the outputs settle.
    task automatic outs(input logic [2:0] e);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({5'h00, switchOutputPin, driverBiasEnable, driverIrqRequest}, {5'h00, e});
    endtask
    task automatic src(input logic [5:0] r);
        @(posedge clk_sys);
        sourceSelect <= lsd_pkg::source_t'(r[5:4]);
        timerLevel <= r[3];
        pwmLevel <= r[2];
    endtask
    initial begin
        {rstn, regWrite, regRead, stopReq, specialMode, timerLevel, pwmLevel, shortLoad} = 8'h00;
        regAddr = 3'h0;
        regWdata = 8'h00;
        sourceSelect = lsd_pkg::SRC_DATA;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        outs(3'b000);
        $display("test reset done");
        wr(3'h1, 8'h01);
        repeat (SETTLE) @(posedge clk_sys);
        rd(3'h1, 8'h01);
        for (int i = 0; i < 7; i++) begin
            src(rows[i]);
            wr(3'h0, {7'h00, rows[i][1]});
            outs({rows[i][0], 2'b10});
            rd(3'h0, {7'h00, rows[i][0]});
        end
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h01);
        outs(3'b000);
        rd(3'h0, 8'h01);
        $display("test sources done");
        wr(3'h3, 8'h5a);
        rd(3'h3, 8'h00);
        @(posedge clk_sys);
        specialMode <= 1'b1;
        wr(3'h3, 8'h5a);
        rd(3'h3, 8'h5a);
        $display("test registers done");
        wr(3'h1, 8'h01);
        src(6'h03);
        wr(3'h6, 8'h80);
        rd(3'h6, 8'h80);
        outs(3'b110);
        @(posedge clk_sys);
        shortLoad <= 1'b1;
        outs(3'b011);
        wr(3'h7, 8'h00);
        rd(3'h7, 8'h01);
        @(posedge clk_sys);
        shortLoad <= 1'b0;
        wr(3'h7, 8'h01);
        outs(3'b110);
        wr(3'h6, 8'h00);
        @(posedge clk_sys);
        shortLoad <= 1'b1;
        outs(3'b010);
        @(posedge clk_sys);
        shortLoad <= 1'b0;
        wr(3'h6, 8'h80);
        outs(3'b011);
        $display("test overcurrent done");
        src(6'h19);
        @(posedge clk_sys);
        stopReq <= 1'b1;
        outs(3'b000);
        @(posedge clk_sys);
        stopReq <= 1'b0;
        outs(3'b011);
        wr(3'h7, 8'h01);
        outs(3'b110);
        src(6'h03);
        outs(3'b010);
        wr(3'h0, 8'h01);
        outs(3'b110);
        src(6'h11);
        @(posedge clk_sys);
        stopReq <= 1'b1;
        outs(3'b000);
        @(posedge clk_sys);
        stopReq <= 1'b0;
        outs(3'b010);
        $display("test stop done");
        src(6'h03);
        wr(3'h0, 8'h01);
        @(posedge clk_sys);
        shortLoad <= 1'b1;
        outs(3'b011);
        @(posedge clk_sys);
        rstn <= 1'b0;
        shortLoad <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        outs(3'b000);
        $display("test reset again done");
        end_of_test();
    end
endmodule
